/* rtl/pfs_sequencer.sv */
// Power-on reset, power-down, thermal and charge-pump sequencer.
//
// Contract
// [R1] Reset held until delay timer reaches threshold.
// [R2] Either supply monitor low asserts reset.
// [R3] Supply recovery mid-retract: finish retract, then delay.
// [R4] Parking configuration bits survive reset.
// [R5] All other writable bits cleared during reset.
// [R6] Spindle brakes while reset is asserted.
// [R7] Falling reset while spinning: tristate spindle, retract.
// [R8] Retract time elapsed: spindle goes tristate to brake.
// [R9] Warning temperature clears the warning status bit.
// [R10] Shutdown: clear bit, tristate spindle, retract, tristate.
// [R11] Thermal shutdown leaves registers unchanged.
// [R12] Outputs off until cooled and run toggled; code also releases when vcm_en_bit toggles.
// [R13] Shutdown bit held until hysteresis cooling.
// [R14] Charge pump runs at its frequency unless disabled.
// [R15] Boost disable bit stops the charge pump.
// [R16] Reset does not stop the charge pump.
// [R17] Delay counter cleared during undervoltage.
// [R18] Comparator inputs pass two synchroniser stages.
`include "pfs_params.svh"

module pfs_sequencer #(
  parameter int POR_DELAY_CYC = `PFS_POR_DELAY_MS * `PFS_CYC_PER_MS,
  parameter int RETRACT_UNIT_CYC = `PFS_RETRACT_UNIT_MS * `PFS_CYC_PER_MS
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Analogue comparators, high when the condition holds
  input wire logic logic_supply_monitor_in,
  input wire logic main_supply_monitor_in,
  input wire logic main_supply_min_in,
  input wire logic temp_warn_in,
  input wire logic temp_shut_in,
  input wire logic temp_cool_in,
  // Motor logic
  input wire logic spindle_spinning_in,
  // Register write and read port
  input wire logic cfg_wr_in,
  input wire logic [3:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [3:0] cfg_raddr_in,
  output logic [7:0] cfg_rdata_out,
  // Sequencer outputs
  output logic supply_good_reset_n_out,
  output pfs_pkg::pfs_drive_s drive_out,
  output logic [1:0] retract_volt_out,
  output logic thermal_warn_n_out,
  output logic thermal_n_out,
  output logic cp_osc_out
);

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  pfs_pkg::pfs_mon_s mon;

  pfs_sync #(
    .W(6)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .async_in({logic_supply_monitor_in, main_supply_monitor_in,
               main_supply_min_in, temp_warn_in, temp_shut_in,
               temp_cool_in}),
    .sync_out(mon)
  ); // see [R18]

  logic supplies_ok;
  assign supplies_ok = mon.logic_ok & mon.main_ok; // see [R2]

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] regs [`PFS_NUM_REGS];
  logic reset_n;

  genvar gi;
  generate
    for (gi = 0; gi < `PFS_NUM_REGS; gi++) begin : g_reg
      localparam logic [7:0] KEEP =
        (gi == 5) ? `PFS_KEEP_CRS_FINE :
        (gi == 8) ? `PFS_KEEP_FLL :
        (gi == 9) ? `PFS_KEEP_SYS_CTRL : 8'h00;
      localparam logic WRITABLE = (gi != 7);
      // Only a real power-on can lose the parking bits; during a supply
      // dip they must still steer the retract that follows.
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          regs[gi] <= 8'h00;
        end else if (!reset_n) begin
          regs[gi] <= regs[gi] & KEEP; // see [R4] see [R5]
        end else if (WRITABLE && cfg_wr_in &&
                     cfg_addr_in == 4'(gi)) begin
          regs[gi] <= cfg_wdata_in;
        end
      end
    end
  endgenerate

  logic run_bit;
  logic spin_en_bit;
  logic vcm_en_bit;
  logic boost_dis_bit;
  logic [1:0] rt_code;
  assign run_bit = regs[`PFS_REG_SPIN_CTRL][`PFS_RUN_BIT];
  assign spin_en_bit = regs[`PFS_REG_SPIN_CTRL][`PFS_SPIN_EN_BIT];
  assign vcm_en_bit = regs[`PFS_REG_SYS_CTRL][`PFS_VCM_EN_BIT];
  assign boost_dis_bit = regs[`PFS_REG_TEST_CTRL][`PFS_BOOST_DIS_BIT];
  assign rt_code = {regs[`PFS_REG_SYS_CTRL][`PFS_RT1_BIT],
                    regs[`PFS_REG_SYS_CTRL][`PFS_RT0_BIT]};

  // Retract length grows in whole units with the programmed code.
  logic [`PFS_CNT_W-1:0] retract_len;
  assign retract_len = `PFS_CNT_W'((32'(rt_code) + 32'd1) *
                                   RETRACT_UNIT_CYC);

  // ----------------------------------------------------------------------
  // Power sequencer
  // ----------------------------------------------------------------------
  pfs_pkg::pfs_state_e state;
  pfs_pkg::pfs_state_e next_state;
  logic [`PFS_CNT_W-1:0] delay_cnt;
  logic delay_done;
  logic pd_start;
  logic pd_busy;
  logic pd_done;

  assign delay_done = (delay_cnt >= `PFS_CNT_W'(POR_DELAY_CYC - 1));

  always_comb begin
    next_state = state;
    pd_start = 1'b0;
    case (state)
      pfs_pkg::PFS_ST_HOLD: begin
        if (supplies_ok) begin
          next_state = pfs_pkg::PFS_ST_DELAY;
        end
      end
      pfs_pkg::PFS_ST_DELAY: begin
        if (!supplies_ok) begin
          next_state = pfs_pkg::PFS_ST_HOLD; // see [R2]
        end else if (delay_done) begin
          next_state = pfs_pkg::PFS_ST_RUN; // see [R1]
        end
      end
      pfs_pkg::PFS_ST_RUN: begin
        if (!supplies_ok) begin
          if (spindle_spinning_in) begin
            next_state = pfs_pkg::PFS_ST_RETRACT; // see [R7]
            pd_start = 1'b1;
          end else begin
            next_state = pfs_pkg::PFS_ST_HOLD;
          end
        end
      end
      pfs_pkg::PFS_ST_RETRACT: begin
        if (pd_done) begin
          // A recovered supply still waits for the full delay.
          next_state = supplies_ok ? pfs_pkg::PFS_ST_DELAY
                                   : pfs_pkg::PFS_ST_HOLD; // see [R3]
        end
      end
      default: begin
        next_state = pfs_pkg::PFS_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= pfs_pkg::PFS_ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Stands in for the delay capacitor: discharged by any undervoltage.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      delay_cnt <= '0;
    end else if (!supplies_ok || state != pfs_pkg::PFS_ST_DELAY) begin
      delay_cnt <= '0; // see [R17]
    end else if (!delay_done) begin
      delay_cnt <= delay_cnt + `PFS_CNT_W'(1); // see [R1]
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reset_n <= 1'b0;
    end else begin
      reset_n <= (next_state == pfs_pkg::PFS_ST_RUN); // see [R1] see [R2]
    end
  end

  pfs_timer #(
    .W(`PFS_CNT_W)
  ) u_pd_timer (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_in(pd_start),
    .len_in(retract_len),
    .busy_out(pd_busy),
    .done_out(pd_done)
  ); // see [R8]

  // ----------------------------------------------------------------------
  // Thermal protection
  // ----------------------------------------------------------------------
  logic shut_flag;
  logic shut_lock;
  logic th_start;
  logic th_busy;
  logic run_q;
  logic vcm_en_q;
  logic ctrl_toggled;

  // The shutdown flag only drops once the die is below the release point.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shut_flag <= 1'b0;
    end else if (mon.temp_shut) begin
      shut_flag <= 1'b1; // see [R10]
    end else if (mon.temp_cool) begin
      shut_flag <= 1'b0; // see [R13]
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      run_q <= 1'b0;
      vcm_en_q <= 1'b0;
    end else begin
      run_q <= run_bit;
      vcm_en_q <= vcm_en_bit;
    end
  end

  assign ctrl_toggled = (run_q != run_bit) || (vcm_en_q != vcm_en_bit);
  assign th_start = shut_flag && !shut_lock;

  // Setting wins over release, so a new trip is never missed.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shut_lock <= 1'b0;
    end else if (shut_flag) begin
      shut_lock <= 1'b1; // see [R10]
    end else if (shut_lock && ctrl_toggled) begin
      shut_lock <= 1'b0; // see [R12]
    end
  end

  pfs_timer #(
    .W(`PFS_CNT_W)
  ) u_th_timer (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .start_in(th_start),
    .len_in(retract_len),
    .busy_out(th_busy),
    .done_out()
  ); // see [R10]

  // ----------------------------------------------------------------------
  // Output stage control
  // ----------------------------------------------------------------------
  pfs_pkg::pfs_drive_s next_drive;

  // Register contents are never touched here, so a thermal trip keeps
  // the whole programmed configuration.
  always_comb begin
    next_drive.spindle = pfs_pkg::PFS_OUT_OFF;
    next_drive.vcm = pfs_pkg::PFS_OUT_OFF;
    if (next_state == pfs_pkg::PFS_ST_RETRACT) begin
      next_drive.spindle = pfs_pkg::PFS_OUT_OFF; // see [R7]
      next_drive.vcm = pfs_pkg::PFS_OUT_RETRACT; // see [R7]
    end else if (next_state != pfs_pkg::PFS_ST_RUN) begin
      next_drive.spindle = pfs_pkg::PFS_OUT_BRAKE; // see [R6] see [R8]
      next_drive.vcm = pfs_pkg::PFS_OUT_OFF;
    end else if (shut_flag || shut_lock) begin
      next_drive.spindle = pfs_pkg::PFS_OUT_OFF; // see [R12] see [R11]
      next_drive.vcm = (th_start || th_busy) ? pfs_pkg::PFS_OUT_RETRACT
                                             : pfs_pkg::PFS_OUT_OFF;
    end else begin
      if (spin_en_bit) begin
        next_drive.spindle = run_bit ? pfs_pkg::PFS_OUT_DRIVE
                                     : pfs_pkg::PFS_OUT_BRAKE;
      end
      if (vcm_en_bit) begin
        next_drive.vcm = pfs_pkg::PFS_OUT_DRIVE;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drive_out <= {pfs_pkg::PFS_OUT_BRAKE, pfs_pkg::PFS_OUT_OFF};
      retract_volt_out <= 2'h0;
      supply_good_reset_n_out <= 1'b0;
    end else begin
      drive_out <= next_drive;
      retract_volt_out <= regs[`PFS_REG_SYS_CTRL][1:0];
      supply_good_reset_n_out <= (next_state == pfs_pkg::PFS_ST_RUN); // see [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Status and read port
  // ----------------------------------------------------------------------
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[`PFS_THERMAL_BIT] = !shut_flag; // see [R10]
    status[`PFS_WARN_BIT] = !mon.temp_warn; // see [R9]
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      thermal_warn_n_out <= 1'b1;
      thermal_n_out <= 1'b1;
    end else begin
      thermal_warn_n_out <= status[`PFS_WARN_BIT]; // see [R9]
      thermal_n_out <= status[`PFS_THERMAL_BIT]; // see [R13]
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_rdata_out <= 8'h00;
    end else if (cfg_raddr_in == `PFS_REG_STATUS) begin
      cfg_rdata_out <= status;
    end else if (cfg_raddr_in == `PFS_REG_CHIP_ID) begin
      // Identity value is arbitrary.
      cfg_rdata_out <= `PFS_CHIP_ID;
    end else if (cfg_raddr_in < 4'(`PFS_NUM_REGS)) begin
      cfg_rdata_out <= regs[cfg_raddr_in];
    end else begin
      cfg_rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Charge-pump oscillator
  // ----------------------------------------------------------------------
  logic [6:0] cp_cnt;
  logic cp_run;

  // Only the test bit and a collapsed main supply stop it; the supply
  // reset does not, since the retract still needs boost.
  assign cp_run = !boost_dis_bit && mon.main_min_ok; // see [R15] see [R16]

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cp_cnt <= 7'h00;
      cp_osc_out <= 1'b0;
    end else if (!cp_run) begin
      cp_cnt <= 7'h00;
      cp_osc_out <= 1'b0; // see [R15]
    end else if (cp_cnt == 7'(`PFS_CP_HALF_CYC - 1)) begin
      cp_cnt <= 7'h00;
      cp_osc_out <= !cp_osc_out; // see [R14]
    end else begin
      cp_cnt <= cp_cnt + 7'h01;
    end
  end

endmodule // pfs_sequencer

/* rtl/pfs_params.svh */
// Constants of the power-fail and thermal sequencer.
`ifndef PFS_PARAMS_SVH
`define PFS_PARAMS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PFS_CLK_HZ 40000000
`define PFS_POR_DELAY_MS 150
`define PFS_RETRACT_UNIT_MS 10
`define PFS_CP_FREQ_HZ 200000
`define PFS_CP_HALF_CYC (`PFS_CLK_HZ / (2 * `PFS_CP_FREQ_HZ))
`define PFS_CYC_PER_MS (`PFS_CLK_HZ / 1000)
`define PFS_CNT_W 24

// ----------------------------------------------------------------------
// Register numbers and fields
// ----------------------------------------------------------------------
`define PFS_NUM_REGS 12
`define PFS_REG_SPIN_CTRL 4'h2
`define PFS_REG_CRS_FINE 4'h5
`define PFS_REG_STATUS 4'h7
`define PFS_REG_FLL 4'h8
`define PFS_REG_SYS_CTRL 4'h9
`define PFS_REG_TEST_CTRL 4'hA
`define PFS_REG_CHIP_ID 4'hC
`define PFS_KEEP_CRS_FINE 8'h08
`define PFS_KEEP_FLL 8'h04
`define PFS_KEEP_SYS_CTRL 8'h4B
`define PFS_RUN_BIT 3
`define PFS_SPIN_EN_BIT 4
`define PFS_VCM_EN_BIT 5
`define PFS_RT0_BIT 3
`define PFS_RT1_BIT 6
`define PFS_BOOST_DIS_BIT 7
`define PFS_THERMAL_BIT 0
`define PFS_WARN_BIT 1
// Identity value is arbitrary.
`define PFS_CHIP_ID 8'h5A

`endif

/* rtl/pfs_pkg.sv */
// Types shared by the sequencer modules.
package pfs_pkg;

  // ----------------------------------------------------------------------
  // Output stage modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_OUT_OFF = 2'b00,
    PFS_OUT_DRIVE = 2'b01,
    PFS_OUT_BRAKE = 2'b10,
    PFS_OUT_RETRACT = 2'b11
  } pfs_out_e;

  typedef struct packed {
    pfs_out_e spindle;
    pfs_out_e vcm;
  } pfs_drive_s;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PFS_ST_HOLD = 2'b00,
    PFS_ST_DELAY = 2'b01,
    PFS_ST_RUN = 2'b10,
    PFS_ST_RETRACT = 2'b11
  } pfs_state_e;

  // Synchronised analogue comparator levels.
  typedef struct packed {
    logic logic_ok;
    logic main_ok;
    logic main_min_ok;
    logic temp_warn;
    logic temp_shut;
    logic temp_cool;
  } pfs_mon_s;

endpackage

/* rtl/pfs_sync.sv */
// Two-stage synchroniser, one chain per bit.
module pfs_sync #(
  parameter int W = 6
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic stage1;
      always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
          stage1 <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1 <= async_in[i];
          sync_out[i] <= stage1;
        end
      end
    end
  endgenerate

endmodule // pfs_sync

/* rtl/pfs_timer.sv */
// One-shot down counter with busy level and done pulse.
module pfs_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Control
  input wire logic start_in,
  input wire logic [W-1:0] len_in,
  // Status
  output logic busy_out,
  output logic done_out
);

  logic [W-1:0] cnt;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt <= '0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt <= len_in;
        busy_out <= 1'b1;
      end else if (busy_out) begin
        if (cnt <= W'(1)) begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          cnt <= '0;
        end else begin
          cnt <= cnt - W'(1);
        end
      end
    end
  end

endmodule // pfs_timer

/* tb/pfs_sequencer_props.sv */
// Assertion checker for the power-fail and thermal sequencer.
module pfs_sequencer_props #(
  parameter int POR_DELAY_CYC = 50,
  parameter int RETRACT_UNIT_CYC = 20
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  // Comparators and motor state
  input wire logic logic_supply_monitor_in,
  input wire logic main_supply_monitor_in,
  input wire logic main_supply_min_in,
  input wire logic temp_warn_in,
  input wire logic temp_shut_in,
  input wire logic temp_cool_in,
  input wire logic spindle_spinning_in,
  // Register port
  input wire logic cfg_wr_in,
  input wire logic [3:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic [3:0] cfg_raddr_in,
  input wire logic [7:0] cfg_rdata_out,
  // Sequencer outputs
  input wire logic supply_good_reset_n_out,
  input wire pfs_pkg::pfs_drive_s drive_out,
  input wire logic [1:0] retract_volt_out,
  input wire logic thermal_warn_n_out,
  input wire logic thermal_n_out,
  input wire logic cp_osc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic sup_ok;
  logic ret_on;
  logic [15:0] ok_cnt;
  logic [15:0] rt_cnt;
  assign sup_ok = logic_supply_monitor_in && main_supply_monitor_in;
  assign ret_on = drive_out.vcm == pfs_pkg::PFS_OUT_RETRACT;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) ok_cnt <= 16'h0000;
    else if (!sup_ok) ok_cnt <= 16'h0000;
    else if (ok_cnt != 16'hFFFF) ok_cnt <= ok_cnt + 16'h0001;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) rt_cnt <= 16'h0000;
    else if (ret_on) rt_cnt <= rt_cnt + 16'h0001;
    else rt_cnt <= 16'h0000;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  a_supply_drop_reset:
    assert property (!sup_ok [*5] |-> !supply_good_reset_n_out)
    else $error("reset not asserted on low supply");
  a_por_delay_met:
    assert property ($rose(supply_good_reset_n_out)
      |-> ok_cnt >= POR_DELAY_CYC)
    else $error("reset released before delay");
  a_reset_brakes:
    assert property (!supply_good_reset_n_out && thermal_n_out && !ret_on
      |-> drive_out.spindle == pfs_pkg::PFS_OUT_BRAKE)
    else $error("spindle not braked in reset");
  a_retract_tristate:
    assert property (ret_on |-> drive_out.spindle == pfs_pkg::PFS_OUT_OFF)
    else $error("spindle driven during retract");
  a_retract_bounded:
    assert property (rt_cnt <= 4 * RETRACT_UNIT_CYC + 1)
    else $error("retract runs too long");
  a_retract_brake:
    assert property ($fell(ret_on) && !supply_good_reset_n_out
      |-> drive_out.spindle == pfs_pkg::PFS_OUT_BRAKE)
    else $error("no brake after retract");
  a_warn_status:
    assert property (temp_warn_in [*5] |-> !thermal_warn_n_out)
    else $error("warning status not cleared");
  a_shut_status:
    assert property (temp_shut_in [*5] |-> !thermal_n_out)
    else $error("shutdown status not cleared");
  a_shut_hyst_hold:
    assert property ((!temp_cool_in && !thermal_n_out) [*4] |=> !thermal_n_out)
    else $error("shutdown released before cooling");
  a_shut_outputs_off:
    assert property (!thermal_n_out [*2]
      |-> drive_out.spindle == pfs_pkg::PFS_OUT_OFF)
    else $error("spindle driven in shutdown");
endmodule // pfs_sequencer_props

bind pfs_sequencer pfs_sequencer_props #(
  .POR_DELAY_CYC(POR_DELAY_CYC),
  .RETRACT_UNIT_CYC(RETRACT_UNIT_CYC)
) props (.*);

/* tb/pfs_ctrl_model.sv */
// Drive controller model that programs the sequencer's register port.
module pfs_ctrl_model (
  // Clock
  input wire logic clk_sys_in,
  // Register port towards the sequencer
  output logic cfg_wr_out,
  output logic [3:0] cfg_addr_out,
  output logic [7:0] cfg_wdata_out,
  output logic [3:0] cfg_raddr_out,
  input wire logic [7:0] cfg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cfg_wr_out = 1'b0;
    cfg_addr_out = 4'h0;
    cfg_wdata_out = 8'h00;
    cfg_raddr_out = 4'h0;
  end

  // Data is inverted once the strobe drops so stale values never pass.
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    cfg_wr_out <= 1'b1;
    cfg_addr_out <= a;
    cfg_wdata_out <= d;
    @(posedge clk_sys_in);
    cfg_wr_out <= 1'b0;
    cfg_wdata_out <= ~d;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    cfg_raddr_out <= a;
    repeat (2) @(posedge clk_sys_in);
    #2;
    d = cfg_rdata_in;
  endtask

  // Parking bits survive reset, so they are rewritten after power-up.
  task automatic park(input logic [7:0] r9);
    write_reg(4'h5, 8'h00);
    write_reg(4'h8, 8'h00);
    write_reg(4'h9, r9);
  endtask

  task automatic toggle_run(input logic [7:0] r2);
    write_reg(4'h2, r2 & 8'hF7);
    write_reg(4'h2, r2);
  endtask
endmodule // pfs_ctrl_model

/* tb/pfs_sequencer_test.sv */
// Self-checking bench for the power-fail and thermal sequencer.
module pfs_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam pfs_pkg::pfs_out_e m_off = pfs_pkg::PFS_OUT_OFF;
  localparam pfs_pkg::pfs_out_e m_drv = pfs_pkg::PFS_OUT_DRIVE;
  localparam pfs_pkg::pfs_out_e m_brk = pfs_pkg::PFS_OUT_BRAKE;
  localparam pfs_pkg::pfs_out_e m_ret = pfs_pkg::PFS_OUT_RETRACT;
  logic clk_sys_in, nrst_in, logic_supply_monitor_in, main_supply_monitor_in;
  logic main_supply_min_in, temp_warn_in, temp_shut_in, temp_cool_in;
  logic spindle_spinning_in, cfg_wr_in, supply_good_reset_n_out;
  logic [3:0] cfg_addr_in, cfg_raddr_in;
  logic [7:0] cfg_wdata_in, cfg_rdata_out, seen, v;
  pfs_pkg::pfs_drive_s drive_out;
  logic [1:0] retract_volt_out;
  logic thermal_warn_n_out, thermal_n_out, cp_osc_out;
  int errors, n_tests, cycles, seed, c;
  logic [7:0] exp_q[$];
  string nam_q[$];
  event got;
  logic [3:0] ka[3] = '{4'h5, 4'h8, 4'h9};
  logic [7:0] kv[3] = '{8'h08, 8'h04, 8'h4B};

  pfs_sequencer #(.POR_DELAY_CYC(50), .RETRACT_UNIT_CYC(20)) dut (
    .clk_sys_in, .nrst_in, .logic_supply_monitor_in, .main_supply_monitor_in,
    .main_supply_min_in, .temp_warn_in, .temp_shut_in, .temp_cool_in,
    .spindle_spinning_in, .cfg_wr_in, .cfg_addr_in, .cfg_wdata_in,
    .cfg_raddr_in, .cfg_rdata_out, .supply_good_reset_n_out, .drive_out,
    .retract_volt_out, .thermal_warn_n_out, .thermal_n_out, .cp_osc_out);
  pfs_ctrl_model ctl (.clk_sys_in, .cfg_wr_out(cfg_wr_in),
    .cfg_addr_out(cfg_addr_in), .cfg_wdata_out(cfg_wdata_in),
    .cfg_raddr_out(cfg_raddr_in), .cfg_rdata_in(cfg_rdata_out));

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic note(input string n, input logic [7:0] e,
                      input logic [7:0] s);
    exp_q.push_back(e);
    nam_q.push_back(n);
    seen = s;
    ->got;
    #1;
  endtask

  initial begin
    forever begin
      @(got);
      n_tests++;
      if (seen !== exp_q[0]) begin
        errors++;
        $display("FAIL %s expected %h seen %h", nam_q[0], exp_q[0], seen);
      end
      void'(exp_q.pop_front());
      void'(nam_q.pop_front());
    end
  end

  function automatic logic [7:0] dv(input pfs_pkg::pfs_out_e s,
                                    input pfs_pkg::pfs_out_e m);
    return {4'h0, s, m};
  endfunction

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #2;
  endtask

  task automatic sup(input logic l, input logic m);
    @(posedge clk_sys_in);
    logic_supply_monitor_in <= l;
    main_supply_monitor_in <= m;
  endtask

  task automatic wait_rst(output int n);
    n = 0;
    while (supply_good_reset_n_out !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic count_cp(input int k, output int n);
    logic p;
    n = 0;
    p = cp_osc_out;
    repeat (k) begin
      cyc(1);
      if (cp_osc_out !== p) n++;
      p = cp_osc_out;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_in, logic_supply_monitor_in, main_supply_monitor_in} = 3'b000;
    {temp_warn_in, temp_shut_in, temp_cool_in} = 3'b000;
    {main_supply_min_in, spindle_spinning_in} = 2'b10;
    seed = 47;
    repeat (12) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    cyc(3);
    note("brake_hold", dv(m_brk, m_off), 8'(drive_out));
    sup(1'b1, 1'b1);
    cyc(30);
    sup(1'b0, 1'b1);
    cyc(3);
    sup(1'b1, 1'b1);
    wait_rst(c);
    note("por_delay", 8'h01, 8'(c >= 50 && c < 70));
    $display("test power_up done");
    v = 8'($random(seed));
    ctl.write_reg(4'h3, v);
    ctl.read_reg(4'h3, seen);
    note("reg3_rw", v, seen);
    for (int i = 0; i < 3; i++) ctl.write_reg(ka[i], 8'h7F);
    sup(1'b1, 1'b0);
    cyc(8);
    sup(1'b1, 1'b1);
    wait_rst(c);
    for (int i = 0; i < 3; i++) begin
      ctl.read_reg(ka[i], v);
      note("kept", kv[i], v);
    end
    ctl.read_reg(4'h3, v);
    note("reg3_clr", 8'h00, v);
    $display("test retention done");
    @(posedge clk_sys_in);
    spindle_spinning_in <= 1'b1;
    ctl.park(8'h6A);
    ctl.write_reg(4'h2, 8'h18);
    sup(1'b0, 1'b1);
    cyc(6);
    note("retract", dv(m_off, m_ret), 8'(drive_out));
    note("ret_volt", 8'h02, 8'(retract_volt_out));
    sup(1'b1, 1'b1);
    cyc(84);
    note("brake_after", dv(m_brk, m_off), 8'(drive_out));
    wait_rst(c);
    note("ret_then_delay", 8'h01, 8'(c + 91 >= 130));
    $display("test power_down done");
    ctl.park(8'h6A);
    ctl.write_reg(4'h2, 8'h18);
    @(posedge clk_sys_in);
    temp_warn_in <= 1'b1;
    cyc(6);
    ctl.read_reg(4'h7, v);
    note("status_warn", 8'h01, v);
    note("warn_n", 8'h00, 8'(thermal_warn_n_out));
    @(posedge clk_sys_in);
    temp_shut_in <= 1'b1;
    cyc(6);
    note("shut_n", 8'h00, 8'(thermal_n_out));
    note("shut_drv", dv(m_off, m_ret), 8'(drive_out));
    cyc(90);
    note("shut_tri", dv(m_off, m_off), 8'(drive_out));
    ctl.read_reg(4'h2, v);
    note("reg2_kept", 8'h18, v);
    @(posedge clk_sys_in);
    {temp_shut_in, temp_warn_in} <= 2'b00;
    cyc(10);
    note("shut_hyst", 8'h00, 8'(thermal_n_out));
    @(posedge clk_sys_in);
    temp_cool_in <= 1'b1;
    cyc(6);
    note("shut_clr", 8'h01, 8'(thermal_n_out));
    note("still_off", dv(m_off, m_off), 8'(drive_out));
    ctl.toggle_run(8'h18);
    cyc(3);
    note("released", dv(m_drv, m_drv), 8'(drive_out));
    @(posedge clk_sys_in);
    temp_cool_in <= 1'b0;
    $display("test thermal done");
    ctl.write_reg(4'hA, 8'h80);
    cyc(5);
    count_cp(300, c);
    note("cp_off", 8'h00, 8'(c));
    ctl.write_reg(4'hA, 8'h00);
    sup(1'b0, 1'b1);
    cyc(5);
    count_cp(1000, c);
    note("cp_run", 8'h0A, 8'(c));
    @(posedge clk_sys_in);
    main_supply_min_in <= 1'b0;
    cyc(5);
    count_cp(300, c);
    note("cp_min", 8'h00, 8'(c));
    $display("test charge_pump done");
    report_and_stop();
  end
endmodule // pfs_sequencer_test
